// *** rtl/rrse_core.sv ***
// Purpose: Executes returns, interrupt entry and return, rotates and bit-skip.
// Assumes: Inputs come from logic on core_clk; operand byte arrives with instr.
// Notes:   One request is taken per ready cycle; interrupt first, then call.
// Notes on behaviour
// RULE_01: Plain return pops PC, three cycles.
// RULE_02: Plain return updates page select bits.
// RULE_03: Call stack separate from software data stack.
// RULE_04: Call pushes following address before jumping.
// RULE_05: Interrupt return restores PC, status; three cycles.
// RULE_06: Option bit 2 restores pre-interrupt speed.
// RULE_07: Option bit 1 stores PC+1 in vector.
// RULE_08: Option bit 0 adds accumulator to timer.
// RULE_09: Interrupt entry saves registers, jumps to vector.
// RULE_10: Page-preserving return pops PC, pages untouched.
// RULE_11: Literal return loads accumulator, pops, three cycles.
// RULE_12: Literal return ignores page bits entirely.
// RULE_13: Rotate left through carry, chosen destination.
// RULE_14: Rotate right through carry, chosen destination.
// RULE_15: Accumulator rotates leave data memory unchanged.
// RULE_16: Rotates take one cycle, touch only carry.
// RULE_17: Skip next instruction when tested bit set.
// RULE_18: Skip operands are bit number and address.
// RULE_19: Skip takes one cycle, two when taken.
// RULE_20: Page select is status bits 7 to 5.
// RULE_21: Stack depth parameter, wraps silently.
`timescale 1ns/1ps
module rrse_core #(
  parameter int STACK_DEPTH = 16
) (
  input  logic                           core_clk,
  input  logic                           srst,
  input  logic                           instr_valid,
  input  logic [15:0]                    instr,
  input  logic [rrse_pkg::DATA_W-1:0]    fr_data,
  input  logic                           call_req,
  input  logic [rrse_pkg::PC_W-1:0]      call_target,
  input  logic                           int_req,
  input  logic [rrse_pkg::DATA_W-1:0]    cur_speed,
  output logic                           ready_q,
  output logic [rrse_pkg::PC_W-1:0]      pc_q,
  output logic [rrse_pkg::DATA_W-1:0]    acc_q,
  output logic [rrse_pkg::DATA_W-1:0]    status_q,
  output logic                           dm_we_q,
  output logic [rrse_pkg::FR_W-1:0]      dm_addr_q,
  output logic [rrse_pkg::DATA_W-1:0]    dm_wdata_q,
  output logic [rrse_pkg::PC_W-1:0]      int_vec_q,
  output logic                           spd_restore_q,
  output logic [rrse_pkg::DATA_W-1:0]    spd_val_q,
  output logic                           t0_add_q,
  output logic [rrse_pkg::DATA_W-1:0]    t0_add_val_q,
  output logic                           skip_q
);
  import rrse_pkg::*;

  function automatic logic op_is(input logic [15:0] w, input logic [15:0] m,
                                 input logic [15:0] v);
    op_is = ((w & m) == v);
  endfunction

  rrse_stk_if #(.AW(PC_W)) stk ();

  rrse_call_stack #(.DEPTH(STACK_DEPTH)) u_stack (
    .core_clk (core_clk),
    .srst     (srst),
    .stk      (stk)
  );

  rrse_state_t        st_q;
  rrse_state_t        st_d;
  logic [1:0]         busy_q;
  logic [1:0]         busy_d;
  logic               ready_d;
  logic [PC_W-1:0]    pc_d;
  logic [DATA_W-1:0]  acc_d;
  logic [DATA_W-1:0]  status_d;
  logic               dm_we_d;
  logic [FR_W-1:0]    dm_addr_d;
  logic [DATA_W-1:0]  dm_wdata_d;
  logic [PC_W-1:0]    int_vec_d;
  logic               spd_restore_d;
  logic [DATA_W-1:0]  spd_val_d;
  logic               t0_add_d;
  logic [DATA_W-1:0]  t0_add_val_d;
  logic               skip_d;
  logic [PC_W-1:0]    sh_pc_q;
  logic [PC_W-1:0]    sh_pc_d;
  logic [DATA_W-1:0]  sh_status_q;
  logic [DATA_W-1:0]  sh_status_d;
  logic [DATA_W-1:0]  sh_acc_q;
  logic [DATA_W-1:0]  sh_acc_d;
  logic [DATA_W-1:0]  sh_speed_q;
  logic [DATA_W-1:0]  sh_speed_d;

  logic               int_take;
  logic               call_take;
  logic               ins_take;
  logic               is_ret;
  logic               is_retnp;
  logic               is_retw;
  logic               is_reti;
  logic               is_rl;
  logic               is_rr;
  logic               is_skip;
  logic [PC_W-1:0]    pc_inc;
  logic [DATA_W-1:0]  rot_res;
  logic               rot_c;

  // Interrupt entry outranks a call, which outranks an ordinary instruction.
  assign int_take  = ready_q & int_req;
  assign call_take = ready_q & ~int_req & call_req;
  assign ins_take  = ready_q & ~int_req & ~call_req & instr_valid;
  assign is_ret    = op_is(instr, OPM_EXACT, OPV_RET);
  assign is_retnp  = op_is(instr, OPM_EXACT, OPV_RETNP);
  assign is_retw   = op_is(instr, OPM_RETW, OPV_RETW);
  assign is_reti   = op_is(instr, OPM_RETI, OPV_RETI);
  assign is_rl     = op_is(instr, OPM_ROT, OPV_RL);
  assign is_rr     = op_is(instr, OPM_ROT, OPV_RR);
  assign is_skip   = op_is(instr, OPM_SKIP, OPV_SKIP);
  assign pc_inc    = pc_q + 16'h0001;

  // The software push/pop stack lives elsewhere; only calls and returns reach
  // this stack.
  assign stk.push  = call_take;                                     // RULE_03
  assign stk.wdata = pc_inc;                                        // RULE_04
  assign stk.pop   = ins_take & (is_ret | is_retnp | is_retw);      // RULE_03

  always_comb begin
    rot_res = fr_data;
    rot_c   = status_q[STAT_C_BIT];
    if (is_rl) begin
      rot_res = {fr_data[DATA_W-2:0], status_q[STAT_C_BIT]};        // RULE_13
      rot_c   = fr_data[DATA_W-1];                                  // RULE_13
    end else if (is_rr) begin
      rot_res = {status_q[STAT_C_BIT], fr_data[DATA_W-1:1]};        // RULE_14
      rot_c   = fr_data[0];                                         // RULE_14
    end
  end

  always_comb begin
    st_d          = st_q;
    busy_d        = busy_q;
    pc_d          = pc_q;
    acc_d         = acc_q;
    status_d      = status_q;
    dm_we_d       = 1'b0;
    dm_addr_d     = dm_addr_q;
    dm_wdata_d    = dm_wdata_q;
    int_vec_d     = int_vec_q;
    spd_restore_d = 1'b0;
    spd_val_d     = spd_val_q;
    t0_add_d      = 1'b0;
    t0_add_val_d  = t0_add_val_q;
    skip_d        = 1'b0;
    sh_pc_d       = sh_pc_q;
    sh_status_d   = sh_status_q;
    sh_acc_d      = sh_acc_q;
    sh_speed_d    = sh_speed_q;
    case (st_q)
      ST_RUN: begin
        if (int_take) begin
          sh_pc_d     = pc_q;                                       // RULE_09
          sh_status_d = status_q;
          sh_acc_d    = acc_q;
          sh_speed_d  = cur_speed;
          pc_d        = int_vec_q;                                  // RULE_09
        end else if (call_take) begin
          pc_d = call_target;                                       // RULE_04
        end else if (ins_take) begin
          pc_d = pc_inc;
          if (is_ret || is_retnp || is_retw) begin
            pc_d   = stk.rdata;                         // RULE_01 RULE_10 RULE_12
            st_d   = ST_WAIT;
            busy_d = RET_EXTRA;                         // RULE_01 RULE_11
            if (is_ret) begin
              status_d[STAT_PAGE_HI:STAT_PAGE_LO] =
                stk.rdata[PC_PAGE_HI:PC_PAGE_LO];       // RULE_02 RULE_20
            end
            if (is_retw) begin
              acc_d = instr[DATA_W-1:0];                            // RULE_11
            end
          end else if (is_reti) begin
            pc_d     = sh_pc_q;                                     // RULE_05
            status_d = sh_status_q;                                 // RULE_05
            st_d     = ST_WAIT;
            busy_d   = RET_EXTRA;                                   // RULE_05
            if (instr[RETI_SPEED_BIT]) begin
              spd_restore_d = 1'b1;                                 // RULE_06
              spd_val_d     = sh_speed_q;
            end
            if (instr[RETI_VEC_BIT]) begin
              int_vec_d = pc_inc;                                   // RULE_07
            end
            if (instr[RETI_TMR_BIT]) begin
              t0_add_d     = 1'b1;                                  // RULE_08
              t0_add_val_d = acc_q;
            end
          end else if (is_rl || is_rr) begin
            status_d[STAT_C_BIT] = rot_c;                           // RULE_16
            if (instr[ROT_DEST_BIT]) begin
              dm_we_d    = 1'b1;
              dm_addr_d  = instr[FR_W-1:0];
              dm_wdata_d = rot_res;
            end else begin
              acc_d = rot_res;                                      // RULE_15
            end
          end else if (is_skip) begin
            if (fr_data[instr[SKIP_BIT_HI:SKIP_BIT_LO]]) begin      // RULE_18
              pc_d   = pc_q + 16'h0002;                             // RULE_17
              skip_d = 1'b1;
              st_d   = ST_SKIP;
              busy_d = SKIP_EXTRA;                                  // RULE_19
            end
          end
        end
      end
      ST_WAIT, ST_SKIP: begin
        busy_d = busy_q - 2'h1;
        if (busy_q == 2'h1) begin
          st_d = ST_RUN;
        end
      end
      default: begin
        st_d   = ST_RUN;
        busy_d = 2'h0;
      end
    endcase
    ready_d = (st_d == ST_RUN);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q          <= ST_RUN;
      busy_q        <= 2'h0;
      ready_q       <= 1'b1;
      pc_q          <= PC_RST;
      acc_q         <= ACC_RST;
      status_q      <= STATUS_RST;
      dm_we_q       <= 1'b0;
      dm_addr_q     <= '0;
      dm_wdata_q    <= '0;
      int_vec_q     <= INT_VEC_RST;
      spd_restore_q <= 1'b0;
      spd_val_q     <= '0;
      t0_add_q      <= 1'b0;
      t0_add_val_q  <= '0;
      skip_q        <= 1'b0;
      sh_pc_q       <= PC_RST;
      sh_status_q   <= STATUS_RST;
      sh_acc_q      <= ACC_RST;
      sh_speed_q    <= '0;
    end else begin
      st_q          <= st_d;
      busy_q        <= busy_d;
      ready_q       <= ready_d;
      pc_q          <= pc_d;
      acc_q         <= acc_d;
      status_q      <= status_d;
      dm_we_q       <= dm_we_d;
      dm_addr_q     <= dm_addr_d;
      dm_wdata_q    <= dm_wdata_d;
      int_vec_q     <= int_vec_d;
      spd_restore_q <= spd_restore_d;
      spd_val_q     <= spd_val_d;
      t0_add_q      <= t0_add_d;
      t0_add_val_q  <= t0_add_val_d;
      skip_q        <= skip_d;
      sh_pc_q       <= sh_pc_d;
      sh_status_q   <= sh_status_d;
      sh_acc_q      <= sh_acc_d;
      sh_speed_q    <= sh_speed_d;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  ret_cycles_a: assert property ( // RULE_01
    ins_take && (is_ret || is_retnp || is_retw) |=> !ready_q [*2] ##1 ready_q)
    else $error("Return did not take three cycles.");

  ret_page_a: assert property ( // RULE_02
    ins_take && is_ret |=>
      status_q[7:5] == $past(stk.rdata[15:13]) && pc_q == $past(stk.rdata))
    else $error("Plain return page bits or target wrong.");

  retnp_page_a: assert property ( // RULE_10
    ins_take && (is_retnp || is_retw) |=> $stable(status_q[7:5]))
    else $error("Page-preserving return altered page bits.");

  reti_restore_a: assert property ( // RULE_05
    ins_take && is_reti |=> pc_q == $past(sh_pc_q) && status_q == $past(sh_status_q)
      ##1 !ready_q ##1 ready_q)
    else $error("Interrupt return restore or timing wrong.");

  reti_speed_a: assert property ( // RULE_06
    ins_take && is_reti |=> spd_restore_q == $past(instr[2]))
    else $error("Speed restore option not honoured.");

  reti_vector_a: assert property ( // RULE_07
    ins_take && is_reti && instr[1] |=> int_vec_q == $past(pc_q) + 16'h0001)
    else $error("Vector not loaded with PC+1.");

  reti_timer_a: assert property ( // RULE_08
    ins_take && is_reti |=> t0_add_q == $past(instr[0])
      && (!t0_add_q || t0_add_val_q == $past(acc_q)))
    else $error("Timer add option wrong.");

  int_entry_a: assert property ( // RULE_09
    int_take |=> pc_q == $past(int_vec_q) && sh_pc_q == $past(pc_q))
    else $error("Interrupt entry did not save and vector.");

  call_push_a: assert property ( // RULE_04
    call_take |=> pc_q == $past(call_target) && stk.rdata == $past(pc_q) + 16'h0001)
    else $error("Call did not push the address after the call.");

  rot_left_a: assert property ( // RULE_13
    ins_take && is_rl && instr[9] |=> dm_we_q
      && dm_wdata_q == {$past(fr_data[6:0]), $past(status_q[0])}
      && status_q[0] == $past(fr_data[7]))
    else $error("Rotate left result wrong.");

  rot_acc_a: assert property ( // RULE_15
    ins_take && (is_rl || is_rr) && !instr[9] |=> !dm_we_q && ready_q
      && status_q[7:1] == $past(status_q[7:1]))
    else $error("Accumulator rotate wrote memory or flags.");

  skip_taken_a: assert property ( // RULE_19
    ins_take && is_skip && fr_data[instr[11:9]] |=> skip_q && !ready_q
      ##1 ready_q && pc_q == $past(pc_q, 2) + 16'h0002)
    else $error("Taken skip timing or target wrong.");

endmodule

// *** rtl/rrse_pkg.sv ***
// Purpose: Shared constants for the return, rotate and bit-skip execute block.
// Assumes: 16-bit instruction words, 16-bit program addresses, 8-bit data.
// Notes:   Opcode matching uses a mask and a value per instruction group.
package rrse_pkg;

  localparam int PC_W   = 16;
  localparam int DATA_W = 8;
  localparam int FR_W   = 9;

  // Opcode masks and values.
  localparam logic [15:0] OPM_EXACT = 16'hffff;
  localparam logic [15:0] OPV_RET   = 16'h0007;
  localparam logic [15:0] OPV_RETNP = 16'h0002;
  localparam logic [15:0] OPM_RETI  = 16'hfff8;
  localparam logic [15:0] OPV_RETI  = 16'h0008;
  localparam logic [15:0] OPM_RETW  = 16'hff00;
  localparam logic [15:0] OPV_RETW  = 16'h7800;
  localparam logic [15:0] OPM_ROT   = 16'hfc00;
  localparam logic [15:0] OPV_RL    = 16'h3400;
  localparam logic [15:0] OPV_RR    = 16'h3000;
  localparam logic [15:0] OPM_SKIP  = 16'hf000;
  localparam logic [15:0] OPV_SKIP  = 16'hb000;

  // Instruction field positions.
  localparam int RETI_SPEED_BIT = 2;
  localparam int RETI_VEC_BIT   = 1;
  localparam int RETI_TMR_BIT   = 0;
  localparam int ROT_DEST_BIT   = 9;
  localparam int SKIP_BIT_HI    = 11;
  localparam int SKIP_BIT_LO    = 9;

  // Status register layout and the matching PC page bits.
  localparam int STAT_C_BIT   = 0;
  localparam int STAT_PAGE_HI = 7;
  localparam int STAT_PAGE_LO = 5;
  localparam int PC_PAGE_HI   = 15;
  localparam int PC_PAGE_LO   = 13;

  // Reset values.
  localparam logic [PC_W-1:0]   PC_RST     = 16'h0000;
  localparam logic [PC_W-1:0]   INT_VEC_RST = 16'h0000;
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
  localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;

  // Cycle counts: extra busy cycles beyond the issue cycle.
  localparam logic [1:0] RET_EXTRA  = 2'h2;
  localparam logic [1:0] SKIP_EXTRA = 2'h1;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_WAIT = 3'b010,
    ST_SKIP = 3'b100
  } rrse_state_t;

endpackage

// *** rtl/rrse_stk_if.sv ***
// Purpose: Carries push and pop requests between the core and its call stack.
// Assumes: One clock; the top entry is readable combinationally.
// Notes:   The core owns the requests, the stack owns the top value.
`timescale 1ns/1ps
interface rrse_stk_if #(parameter int AW = 16);
  logic          push;
  logic          pop;
  logic [AW-1:0] wdata;
  logic [AW-1:0] rdata;

  modport owner (output push, output pop, output wdata, input rdata);
  modport store (input push, input pop, input wdata, output rdata);
endinterface

// *** rtl/rrse_call_stack.sv ***
// Purpose: Hardware call/return stack holding full program addresses.
// Assumes: Push and pop never arrive in the same cycle.
// Notes:   Pointer wraps silently on overflow and underflow.
`timescale 1ns/1ps
module rrse_call_stack #(
  parameter int DEPTH = 16
) (
  input  logic         core_clk,
  input  logic         srst,
  rrse_stk_if.store    stk
);
  import rrse_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [PC_W-1:0] mem_q [DEPTH];
  logic [PW-1:0]   sp_q;
  logic [PW-1:0]   sp_d;
  logic [PW-1:0]   top_idx;

  // The pointer marks the next free slot; the top is one below it.
  always_comb begin
    top_idx = sp_q - 1'b1;
    sp_d    = sp_q;
    if (stk.push) begin
      sp_d = sp_q + 1'b1;
    end else if (stk.pop) begin
      sp_d = top_idx;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sp_q <= '0;
    end else begin
      sp_q <= sp_d;  // RULE_21
    end
    if (stk.push) begin
      mem_q[sp_q] <= stk.wdata;
    end
  end

  assign stk.rdata = mem_q[top_idx];

endmodule

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the return, rotate and bit-skip execute block.
// Assumes: Requests are taken on a rising edge while ready_q is high.
// Notes:   A small model tracks pc, accumulator, status, vector and the call stack.
`timescale 1ns/1ps
module tb;
  import rrse_pkg::*;

  logic                core_clk;
  logic                srst;
  logic                instr_valid;
  logic [15:0]         instr;
  logic [DATA_W-1:0]   fr_data;
  logic                call_req;
  logic [PC_W-1:0]     call_target;
  logic                int_req;
  logic [DATA_W-1:0]   cur_speed;
  logic                ready_q;
  logic [PC_W-1:0]     pc_q;
  logic [DATA_W-1:0]   acc_q;
  logic [DATA_W-1:0]   status_q;
  logic                dm_we_q;
  logic [FR_W-1:0]     dm_addr_q;
  logic [DATA_W-1:0]   dm_wdata_q;
  logic [PC_W-1:0]     int_vec_q;
  logic                spd_restore_q;
  logic [DATA_W-1:0]   spd_val_q;
  logic                t0_add_q;
  logic [DATA_W-1:0]   t0_add_val_q;
  logic                skip_q;
  int                  num_errors;
  int                  check_count;
  logic [15:0]         e_pc;
  logic [15:0]         e_vec;
  logic [7:0]          e_acc;
  logic [7:0]          e_st;
  logic [7:0]          e_spd;
  logic [15:0]         stk[$];

  rrse_core rrse_core_inst (
    .core_clk(core_clk), .srst(srst), .instr_valid(instr_valid), .instr(instr),
    .fr_data(fr_data), .call_req(call_req), .call_target(call_target),
    .int_req(int_req), .cur_speed(cur_speed), .ready_q(ready_q), .pc_q(pc_q),
    .acc_q(acc_q), .status_q(status_q), .dm_we_q(dm_we_q), .dm_addr_q(dm_addr_q),
    .dm_wdata_q(dm_wdata_q), .int_vec_q(int_vec_q), .spd_restore_q(spd_restore_q),
    .spd_val_q(spd_val_q), .t0_add_q(t0_add_q), .t0_add_val_q(t0_add_val_q),
    .skip_q(skip_q)
  );

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_state();
    chk_val(pc_q, e_pc, "pc");
    chk_val(acc_q, e_acc, "acc");
    chk_val(status_q, e_st, "status");
  endtask

  task automatic issue(input logic [15:0] op, input logic [7:0] fr);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr       <= op;
    fr_data     <= fr;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    fr_data     <= ~fr;
    #1;
  endtask

  // Called in the first cycle after a return was taken.
  task automatic wait_ret();
    chk_val(ready_q, 1'b0, "ready c1");
    @(posedge core_clk);
    #1;
    chk_val(ready_q, 1'b0, "ready c2");
    @(posedge core_clk);
    #1;
    chk_val(ready_q, 1'b1, "ready c3");
  endtask

  task automatic do_call(input logic [15:0] t);
    @(posedge core_clk);
    call_req    <= 1'b1;
    call_target <= t;
    @(posedge core_clk);
    call_req    <= 1'b0;
    #1;
    stk.push_back(e_pc + 16'h0001);
    e_pc = t;
    chk_state();
  endtask

  task automatic do_ret(input logic [15:0] op);
    issue(op, 8'h00);
    e_pc = stk.pop_back();
    if (op == OPV_RET) e_st[7:5] = e_pc[15:13];
    if (op[15:8] == 8'h78) e_acc = op[7:0];
    chk_state();
    wait_ret();
  endtask

  task automatic do_rot(input logic [15:0] op, input logic [7:0] fr);
    logic [7:0] res;
    logic       nc;
    if (op[10]) begin
      res = {fr[6:0], e_st[0]};
      nc  = fr[7];
    end else begin
      res = {e_st[0], fr[7:1]};
      nc  = fr[0];
    end
    issue(op, fr);
    e_st[0] = nc;
    e_pc    = e_pc + 16'h0001;
    if (op[9]) begin
      chk_val(dm_we_q, 1'b1, "rot we");
      chk_val(dm_wdata_q, res, "rot data");
      chk_val(dm_addr_q, op[8:0], "rot addr");
    end else begin
      chk_val(dm_we_q, 1'b0, "rot w we");
      e_acc = res;
    end
    chk_state();
    chk_val(ready_q, 1'b1, "rot ready");
  endtask

  task automatic do_skip(input int b, input logic set);
    logic [7:0] m;
    m = 8'h01 << b;
    issue(OPV_SKIP | (16'(b) << 9) | 16'h00a5, set ? m : ~m);
    e_pc = e_pc + (set ? 16'h0002 : 16'h0001);
    chk_state();
    chk_val(skip_q, set, "skip pulse");
    chk_val(ready_q, !set, "skip ready c1");
    @(posedge core_clk);
    #1;
    chk_val(ready_q, 1'b1, "skip ready c2");
    chk_val(skip_q, 1'b0, "skip drop");
  endtask

  task automatic do_int_reti(input logic [2:0] n);
    logic [15:0] sv_pc;
    logic [7:0]  sv_st;
    logic [15:0] rpc;
    sv_pc = e_pc;
    sv_st = e_st;
    @(posedge core_clk);
    int_req   <= 1'b1;
    cur_speed <= 8'h30 + 8'(n);
    @(posedge core_clk);
    int_req   <= 1'b0;
    #1;
    e_pc = e_vec;
    chk_state();
    do_rot(16'h3499, 8'h81 ^ 8'(n));
    rpc = e_pc;
    issue(OPV_RETI | 16'(n), 8'h00);
    e_pc = sv_pc;
    e_st = sv_st;
    if (n[1]) e_vec = rpc + 16'h0001;
    chk_state();
    chk_val(int_vec_q, e_vec, "vector");
    chk_val(spd_restore_q, n[2], "speed pulse");
    if (n[2]) e_spd = 8'h30 + 8'(n);
    chk_val(spd_val_q, e_spd, "speed value");
    chk_val(t0_add_q, n[0], "timer pulse");
    if (n[0]) chk_val(t0_add_val_q, e_acc, "timer value");
    wait_ret();
  endtask

  initial begin
    num_errors  = 0;
    check_count = 0;
    srst        = 1'b1;
    instr_valid = 1'b0;
    instr       = 16'h0000;
    fr_data     = 8'h00;
    call_req    = 1'b0;
    call_target = 16'h0000;
    int_req     = 1'b0;
    cur_speed   = 8'h00;
    e_pc = PC_RST;
    e_vec = INT_VEC_RST;
    e_acc = ACC_RST;
    e_st = STATUS_RST;
    e_spd = 8'h00;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk_state();
    chk_val(int_vec_q, 16'h0000, "vector reset");
    chk_val(ready_q, 1'b1, "ready reset");
    do_call(16'ha000);
    do_call(16'h2345);
    do_ret(OPV_RET);
    do_ret(OPV_RETNP);
    do_call(16'hc000);
    do_call(16'h4000);
    do_ret(OPV_RETW | 16'h005a);
    do_ret(OPV_RET);
    do_rot(16'h3499, 8'h80);
    do_rot(16'h3699, 8'h14);
    do_rot(16'h3400, 8'h94);
    do_rot(16'h32ff, 8'h12);
    do_rot(16'h3010, 8'h13);
    do_rot(16'h3201, 8'h01);
    for (int b = 0; b < 8; b++) begin
      do_skip(b, 1'b1);
      do_skip(b, 1'b0);
    end
    for (int n = 0; n < 8; n++) begin
      do_int_reti(3'(n));
    end
    tally_and_finish();
  end

  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
endmodule
